// ===== vecrx_pkg.sv
// Purpose: shared constants and types for the vector plot receiver
// Assumes: 100 MHz core clock
// Notes:   times are kept in their own unit, cycle counts derived here
package vecrx_pkg;

	// core clock rate
	localparam int CLK_MHZ = 100;

	// timing figures in their own units
	localparam int SYNC_NS    = 1000;
	localparam int GAP_NS     = 500;
	localparam int WDONE_NS   = 1000;
	localparam int STRETCH_US = 100;
	localparam int RUN_PULSE_NS    = 500;
	localparam int VDONE_NS   = 1000;
	localparam int BUSY_US    = 2500;

	// timer width, wide enough for the busy interval
	localparam int TW = 18;

	// derived cycle counts
	localparam logic [TW-1:0] SYNC_CYC  = TW'(SYNC_NS * CLK_MHZ / 1000);
	localparam logic [TW-1:0] GAP_CYC   = TW'(GAP_NS * CLK_MHZ / 1000);
	localparam logic [TW-1:0] WDONE_CYC = TW'(WDONE_NS * CLK_MHZ / 1000);
	localparam logic [TW-1:0] RUN_PULSE_CYC  = TW'(RUN_PULSE_NS * CLK_MHZ / 1000);
	localparam logic [TW-1:0] VDONE_CYC = TW'(VDONE_NS * CLK_MHZ / 1000);
	localparam int STRETCH_CYC_DEF = STRETCH_US * CLK_MHZ;
	localparam int BUSY_CYC_DEF    = BUSY_US * CLK_MHZ;

	// control character codes
	localparam logic [7:0] CH_GS = 8'h1D;
	localparam logic [7:0] CH_US = 8'h1F;
	localparam logic [7:0] CH_RS = 8'h1E;
	localparam logic [7:0] CH_FS = 8'h1C;
	localparam logic [7:0] CH_CR = 8'h0D;

	// register byte offsets
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_POS    = 4'h8;

	// control register fields
	localparam int CTRL_ORDER_LSB = 0;
	localparam int CTRL_CR_EXIT   = 2;
	localparam int CTRL_LATE_REV  = 3;
	localparam logic [3:0] CTRL_RESET = 4'h8;

	// status register fields
	localparam int ST_TEXT  = 0;
	localparam int ST_DARK  = 1;
	localparam int ST_BUSYN = 2;
	localparam int ST_READY = 3;
	localparam int ST_IDX   = 4;

	// position register fields
	localparam int POS_X_LSB = 0;
	localparam int POS_Y_LSB = 16;

	// register-half codes in default order
	localparam logic [1:0] HALF_HY = 2'd0;
	localparam logic [1:0] HALF_LY = 2'd1;
	localparam logic [1:0] HALF_HX = 2'd2;
	localparam logic [1:0] HALF_LX = 2'd3;

	// register-half load pulses
	typedef struct packed {
		logic high_y_load;
		logic low_y_load;
		logic high_x_load;
		logic low_x_load;
	} vecrx_loads_t;

	// view restore outputs
	typedef struct packed {
		logic view_lamp;
		logic hold_n;
		logic view;
	} vecrx_view_t;

endpackage

// ===== vecrx_timer.sv
// Purpose: one-shot down counter used for every timed interval
// Assumes: start is a single-cycle pulse with the length in value_in
// Notes:   done_out pulses in the last counted cycle
`timescale 1ns/1ps
`default_nettype none
module vecrx_timer
	import vecrx_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	input  wire logic          ce_in,
	input  wire logic          start_in,
	input  wire logic [TW-1:0] value_in,
	output logic               done_out
);

	logic [TW-1:0] cnt_ff;

	// load one short: the start flop upstream already cost a cycle
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= '0;
		end else if (ce_in) begin
			if (start_in) begin
				cnt_ff <= value_in - TW'(1);
			end else if (cnt_ff != '0) begin
				cnt_ff <= cnt_ff - TW'(1);
			end
		end
	end

	assign done_out = ce_in && !start_in && (cnt_ff == TW'(1));

endmodule
`default_nettype wire

// ===== vecrx_top.sv
// Purpose: linear-interpolate vector receive control for a storage tube
// Assumes: byte strobe, data and slew amplitudes arrive asynchronously
// Notes:   control bits sit in a small avalon-mm register file
//
// Summary of operation
// - GS in text mode: vector mode, dark, loads off
// - default byte order high Y, low Y, high X, low X
// - byte strobe drops ready, makes load strobe
// - second byte loads Y weights 1 to 16
// - third byte loads X weights 32 to 512
// - late revision clears data lines after low X
// - fourth byte stretches load strobe 100 us
// - stretch end gives half-us execute strobe
// - execute strobe runs view restore
// - execute strobe loads converters, busy low
// - dark flag makes converters move fast
// - loads end, then busy high, dark clears
// - busy rise gives done pulse, function complete
// - later vectors slewed slowly and unblanked
// - larger slew amplitude drives beam unblank
// - written vector holds busy low 2.5 ms
// - strap selects other byte order
// - bits 7,6 low: control character handling
// - after control character resume vector assembly
// - RS, FS give no execute strobe in vector mode
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module vecrx_top
	import vecrx_pkg::*;
#(
	parameter int STRETCH_CYC = STRETCH_CYC_DEF,
	parameter int BUSY_CYC    = BUSY_CYC_DEF
) (
	input  wire logic        core_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        ce_in,
	input  wire logic        receive_byte_strobe_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic [7:0]  delta_x_in,
	input  wire logic [7:0]  delta_y_in,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic             receive_ready_line_out,
	output logic             text_mode_flag_out,
	output logic             first_vector_dark_flag_out,
	output logic             vector_in_progress_n_out,
	output logic             x_conv_load_out,
	output logic             y_conv_load_out,
	output logic [9:0]       x_conv_out,
	output logic [9:0]       y_conv_out,
	output logic             beam_unblank_out,
	output logic             execute_strobe_out,
	output logic             run_pulse_out,
	output logic             function_complete_out,
	output logic             vector_done_pulse_out,
	output logic             word_done_pulse_out,
	output logic             synchronous_load_strobe_out,
	output vecrx_loads_t     loads_out,
	output logic [7:0]       latched_data_lines_out,
	output vecrx_view_t      view_out
);

	typedef enum {
		S_IDLE, S_SYNC, S_GAP, S_WDONE, S_CTRL,
		S_RUN_PULSE, S_SETTLE, S_BUSY, S_VDONE
	} vecrx_state_t;

	vecrx_state_t  state_ff;
	logic [1:0]    rst_sync_ff;
	logic          rst_n;
	logic [2:0]    stb_sync_ff;
	logic          stb_lvl_ff;
	logic [7:0]    dat_s1_ff, dat_s2_ff, dat_s3_ff;
	logic [7:0]    dx_s1_ff, dx_s2_ff, dx_s3_ff;
	logic [7:0]    dy_s1_ff, dy_s2_ff, dy_s3_ff;
	logic          stb_rise;
	logic [3:0]    ctrl_ff;
	logic          waitreq_ff;
	logic [31:0]   rdata_ff;
	logic          vec_mode_ff;
	logic          ctrl_active_ff;
	logic [1:0]    byte_idx_ff;
	logic          last_byte_ff;
	logic [4:0]    x_hi_ff, x_lo_ff, y_hi_ff, y_lo_ff;
	logic          tstart_ff;
	logic [TW-1:0] tval_ff;
	logic          tdone;
	logic [1:0]    half;
	logic          is_ctrl;
	logic [7:0]    amp_max;
	logic          bus_req;

	// reset release through two flops
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// three-flop synchronisers for pin inputs
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			stb_sync_ff <= 3'b000;
			stb_lvl_ff  <= 1'b0;
			dat_s1_ff   <= 8'h00;
			dat_s2_ff   <= 8'h00;
			dat_s3_ff   <= 8'h00;
			dx_s1_ff    <= 8'h00;
			dx_s2_ff    <= 8'h00;
			dx_s3_ff    <= 8'h00;
			dy_s1_ff    <= 8'h00;
			dy_s2_ff    <= 8'h00;
			dy_s3_ff    <= 8'h00;
		end else if (ce_in) begin
			stb_sync_ff <= {stb_sync_ff[1:0], receive_byte_strobe_in};
			if (stb_sync_ff[1] == stb_sync_ff[2]) begin
				stb_lvl_ff <= stb_sync_ff[2];
			end
			dat_s1_ff   <= rx_data_in;
			dat_s2_ff   <= dat_s1_ff;
			dat_s3_ff   <= dat_s2_ff;
			dx_s1_ff    <= delta_x_in;
			dx_s2_ff    <= dx_s1_ff;
			dx_s3_ff    <= dx_s2_ff;
			dy_s1_ff    <= delta_y_in;
			dy_s2_ff    <= dy_s1_ff;
			dy_s3_ff    <= dy_s2_ff;
		end
	end

	// strobe counts once stages two and three agree on a rise
	assign stb_rise = stb_sync_ff[1] && stb_sync_ff[2] && !stb_lvl_ff;
	assign half     = byte_idx_ff ^ ctrl_ff[CTRL_ORDER_LSB +: 2];
	assign is_ctrl  = (dat_s3_ff[7:6] == 2'b00);
	assign amp_max  = (dx_s3_ff > dy_s3_ff) ? dx_s3_ff : dy_s3_ff;
	assign bus_req  = avs_read_in || avs_write_in;

	// one-shot timer for all intervals
	vecrx_timer u_timer (
		.clk_in   (core_clk_in),
		.rst_n_in (rst_n),
		.ce_in    (ce_in),
		.start_in (tstart_ff),
		.value_in (tval_ff),
		.done_out (tdone)
	);

	// avalon slave: one wait cycle, then the answer
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			waitreq_ff <= 1'b1;
			rdata_ff   <= 32'h0000_0000;
			ctrl_ff    <= CTRL_RESET;
		end else if (ce_in) begin
			waitreq_ff <= !(bus_req && waitreq_ff);
			if (bus_req && waitreq_ff) begin
				rdata_ff <= 32'h0000_0000;
				unique case (avs_address_in)
					OFS_CTRL: rdata_ff[3:0] <= ctrl_ff;
					OFS_STATUS: begin
						rdata_ff[ST_TEXT]  <= text_mode_flag_out;
						rdata_ff[ST_DARK]  <= first_vector_dark_flag_out;
						rdata_ff[ST_BUSYN] <= vector_in_progress_n_out;
						rdata_ff[ST_READY] <= receive_ready_line_out;
						rdata_ff[ST_IDX +: 2] <= byte_idx_ff;
					end
					OFS_POS: begin
						rdata_ff[POS_X_LSB +: 10] <= x_conv_out;
						rdata_ff[POS_Y_LSB +: 10] <= y_conv_out;
					end
					default: rdata_ff <= 32'h0000_0000;
				endcase
			end
			if (avs_write_in && !waitreq_ff && avs_address_in == OFS_CTRL) begin
				ctrl_ff <= avs_writedata_in[3:0];
			end
		end
	end
	assign avs_waitrequest_out = waitreq_ff;
	assign avs_readdata_out    = rdata_ff;

	// receive sequencer
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_ff                    <= S_IDLE;
			vec_mode_ff                 <= 1'b0;
			ctrl_active_ff              <= 1'b0;
			first_vector_dark_flag_out  <= 1'b0;
			receive_ready_line_out      <= 1'b1;
			byte_idx_ff                 <= 2'd0;
			last_byte_ff                <= 1'b0;
			tstart_ff                   <= 1'b0;
			tval_ff                     <= '0;
			synchronous_load_strobe_out <= 1'b0;
			loads_out                   <= '0;
			latched_data_lines_out      <= 8'h00;
			function_complete_out       <= 1'b0;
			word_done_pulse_out         <= 1'b0;
			vector_done_pulse_out       <= 1'b0;
			execute_strobe_out          <= 1'b0;
			run_pulse_out               <= 1'b0;
			x_conv_load_out             <= 1'b0;
			y_conv_load_out             <= 1'b0;
			vector_in_progress_n_out    <= 1'b1;
		end else if (ce_in) begin
			tstart_ff             <= 1'b0;
			function_complete_out <= 1'b0;
			run_pulse_out         <= 1'b0;
			unique case (state_ff)
				S_IDLE: begin
					if (stb_rise) begin
						receive_ready_line_out      <= 1'b0;
						latched_data_lines_out      <= dat_s3_ff;
						tstart_ff                   <= 1'b1;
						if (!vec_mode_ff || is_ctrl) begin
							ctrl_active_ff <= vec_mode_ff;
							if (!vec_mode_ff && dat_s3_ff == CH_GS) begin
								vec_mode_ff                <= 1'b1;
								first_vector_dark_flag_out <= 1'b1;
								byte_idx_ff                <= 2'd0;
							end else if (vec_mode_ff && dat_s3_ff == CH_GS) begin
								first_vector_dark_flag_out <= 1'b1;
								byte_idx_ff                <= 2'd0;
							end else if (vec_mode_ff && (dat_s3_ff == CH_US ||
								(dat_s3_ff == CH_CR && ctrl_ff[CTRL_CR_EXIT]))) begin
								vec_mode_ff <= 1'b0;
							end
							// RS and FS give no execute strobe or run pulse in vector mode
							execute_strobe_out <= !(vec_mode_ff &&
								(dat_s3_ff == CH_RS || dat_s3_ff == CH_FS));
							run_pulse_out <= !(vec_mode_ff &&
								(dat_s3_ff == CH_RS || dat_s3_ff == CH_FS));
							tval_ff  <= RUN_PULSE_CYC;
							state_ff <= S_CTRL;
						end else begin
							synchronous_load_strobe_out <= 1'b1;
							loads_out.high_y_load <= (half == HALF_HY);
							loads_out.low_y_load  <= (half == HALF_LY);
							loads_out.high_x_load <= (half == HALF_HX);
							loads_out.low_x_load  <= (half == HALF_LX);
							last_byte_ff <= (byte_idx_ff == 2'd3);
							byte_idx_ff  <= byte_idx_ff + 2'd1;
							tval_ff <= (byte_idx_ff == 2'd3) ?
								TW'(STRETCH_CYC) : SYNC_CYC;
							state_ff <= S_SYNC;
						end
					end
				end
				S_SYNC: begin
					if (tdone) begin
						loads_out <= '0;
						tstart_ff <= 1'b1;
						if (last_byte_ff) begin
							if (ctrl_ff[CTRL_LATE_REV]) begin
								latched_data_lines_out <= 8'h00;
							end
							synchronous_load_strobe_out <= 1'b0;
							execute_strobe_out          <= 1'b1;
							run_pulse_out               <= 1'b1;
							x_conv_load_out             <= 1'b1;
							y_conv_load_out             <= 1'b1;
							vector_in_progress_n_out    <= 1'b0;
							tval_ff  <= RUN_PULSE_CYC;
							state_ff <= S_RUN_PULSE;
						end else begin
							synchronous_load_strobe_out <= 1'b0;
							tval_ff  <= GAP_CYC;
							state_ff <= S_GAP;
						end
					end
				end
				S_GAP: begin
					if (tdone) begin
						word_done_pulse_out   <= 1'b1;
						function_complete_out <= 1'b1;
						tstart_ff <= 1'b1;
						tval_ff   <= WDONE_CYC;
						state_ff  <= S_WDONE;
					end
				end
				S_WDONE: begin
					if (tdone) begin
						word_done_pulse_out    <= 1'b0;
						latched_data_lines_out <= 8'h00;
						receive_ready_line_out <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
				S_CTRL: begin
					if (tdone) begin
						execute_strobe_out     <= 1'b0;
						function_complete_out  <= 1'b1;
						latched_data_lines_out <= 8'h00;
						receive_ready_line_out <= 1'b1;
						ctrl_active_ff         <= 1'b0;
						state_ff <= S_IDLE;
					end
				end
				S_RUN_PULSE: begin
					if (tdone) begin
						execute_strobe_out <= 1'b0;
						x_conv_load_out    <= 1'b0;
						y_conv_load_out    <= 1'b0;
						state_ff <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					tstart_ff <= 1'b1;
					if (first_vector_dark_flag_out) begin
						vector_in_progress_n_out   <= 1'b1;
						first_vector_dark_flag_out <= 1'b0;
						vector_done_pulse_out      <= 1'b1;
						function_complete_out      <= 1'b1;
						tval_ff  <= VDONE_CYC;
						state_ff <= S_VDONE;
					end else begin
						tval_ff  <= TW'(BUSY_CYC);
						state_ff <= S_BUSY;
					end
				end
				S_BUSY: begin
					if (tdone) begin
						vector_in_progress_n_out <= 1'b1;
						vector_done_pulse_out    <= 1'b1;
						function_complete_out    <= 1'b1;
						tstart_ff <= 1'b1;
						tval_ff   <= VDONE_CYC;
						state_ff  <= S_VDONE;
					end
				end
				S_VDONE: begin
					if (tdone) begin
						vector_done_pulse_out  <= 1'b0;
						latched_data_lines_out <= 8'h00;
						receive_ready_line_out <= 1'b1;
						state_ff <= S_IDLE;
					end
				end
			endcase
		end
	end

	// data register halves follow their load pulses
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			y_hi_ff <= 5'h00;
			y_lo_ff <= 5'h00;
			x_hi_ff <= 5'h00;
			x_lo_ff <= 5'h00;
		end else if (ce_in) begin
			if (loads_out.high_y_load) y_hi_ff <= latched_data_lines_out[4:0];
			if (loads_out.low_y_load)  y_lo_ff <= latched_data_lines_out[4:0];
			if (loads_out.high_x_load) x_hi_ff <= latched_data_lines_out[4:0];
			if (loads_out.low_x_load)  x_lo_ff <= latched_data_lines_out[4:0];
		end
	end

	// converters take both registers only on their load lines
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			x_conv_out <= 10'h000;
			y_conv_out <= 10'h000;
		end else if (ce_in) begin
			if (x_conv_load_out) x_conv_out <= {x_hi_ff, x_lo_ff};
			if (y_conv_load_out) y_conv_out <= {y_hi_ff, y_lo_ff};
		end
	end

	// unblank only on written vectors, by the larger slew amplitude
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			beam_unblank_out <= 1'b0;
		end else if (ce_in) begin
			beam_unblank_out <= !vector_in_progress_n_out &&
				!first_vector_dark_flag_out && (amp_max != 8'h00);
		end
	end

	// view restore on each run pulse
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			view_out <= '{view_lamp: 1'b0, hold_n: 1'b1, view: 1'b0};
		end else if (ce_in && run_pulse_out) begin
			view_out <= '{view_lamp: 1'b1, hold_n: 1'b1, view: 1'b0};
		end
	end

	// text flag high outside vector mode and during control handling
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			text_mode_flag_out <= 1'b1;
		end else if (ce_in) begin
			text_mode_flag_out <= !vec_mode_ff || ctrl_active_ff;
		end
	end

endmodule
`default_nettype wire

// ===== vecrx_chk.sv
// Purpose: port assertions for the vector plot receiver
// Assumes: bound to vecrx_top, one clock domain
// Notes:   long intervals measured by helper counters
`timescale 1ns/1ps
`default_nettype none
module vecrx_chk
	import vecrx_pkg::*;
#(
	parameter int STRETCH_CYC = 20,
	parameter int BUSY_CYC    = 40
) (
	input wire logic         core_clk_in,
	input wire logic         arst_n_in,
	input wire logic         receive_ready_line_out,
	input wire logic         first_vector_dark_flag_out,
	input wire logic         vector_in_progress_n_out,
	input wire logic         x_conv_load_out,
	input wire logic         y_conv_load_out,
	input wire logic         beam_unblank_out,
	input wire logic         execute_strobe_out,
	input wire logic         run_pulse_out,
	input wire logic         vector_done_pulse_out,
	input wire logic         synchronous_load_strobe_out,
	input wire vecrx_loads_t loads_out,
	input wire vecrx_view_t  view_out
);
	logic [TW-1:0] ex_cnt_ff;
	logic [TW-1:0] ls_cnt_ff;
	logic [TW-1:0] bz_cnt_ff;

	// lengths of execute, load strobe and busy
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ex_cnt_ff <= '0;
			ls_cnt_ff <= '0;
			bz_cnt_ff <= '0;
		end else begin
			ex_cnt_ff <= execute_strobe_out ? ex_cnt_ff + 1'b1 : '0;
			ls_cnt_ff <= synchronous_load_strobe_out ? ls_cnt_ff + 1'b1 : '0;
			bz_cnt_ff <= !vector_in_progress_n_out ? bz_cnt_ff + 1'b1 : '0;
		end
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	// converter loads only inside execute, busy low
	chk_run_pulse_loads: assert property ((x_conv_load_out || y_conv_load_out) |->
		execute_strobe_out && x_conv_load_out && y_conv_load_out
		&& !vector_in_progress_n_out) else $error("loads outside execute");
	chk_run_pulse_len: assert property ($fell(execute_strobe_out) |->
		ex_cnt_ff == RUN_PULSE_CYC) else $error("execute length wrong");
	chk_stretch_run_pulse: assert property ($fell(synchronous_load_strobe_out)
		&& ls_cnt_ff == STRETCH_CYC |-> ##[0:2] $rose(execute_strobe_out))
		else $error("no execute after stretch");
	chk_load_strobe: assert property ((|loads_out) |->
		synchronous_load_strobe_out && !receive_ready_line_out)
		else $error("load pulse without strobe");
	chk_one_load: assert property ($onehot0(loads_out))
		else $error("several half loads");
	chk_run_pulse_run: assert property ($rose(execute_strobe_out) |->
		##[0:2] run_pulse_out) else $error("no run pulse");
	chk_run_view: assert property ($rose(run_pulse_out) |->
		##[0:3] (view_out == 3'b110)) else $error("view not restored");
	chk_loads_end: assert property ($fell(execute_strobe_out) |->
		!x_conv_load_out && !y_conv_load_out) else $error("loads linger");
	chk_busy_done: assert property ($rose(vector_in_progress_n_out) |->
		##[0:1] (vector_done_pulse_out && !first_vector_dark_flag_out))
		else $error("no done pulse or dark kept");
	chk_busy_len: assert property ($rose(vector_in_progress_n_out) |->
		($past(first_vector_dark_flag_out) ? bz_cnt_ff <= RUN_PULSE_CYC + 2
		: bz_cnt_ff >= BUSY_CYC)) else $error("busy length wrong");
	chk_dark_blank: assert property (first_vector_dark_flag_out |->
		!beam_unblank_out) else $error("dark vector unblanked");

	cov_dark_run_pulse: cover property ($rose(execute_strobe_out)
		&& first_vector_dark_flag_out);
	cov_unblank: cover property ($rose(beam_unblank_out));
	cov_ready_drop: cover property ($fell(receive_ready_line_out));
endmodule

bind vecrx_top vecrx_chk #(.STRETCH_CYC(STRETCH_CYC), .BUSY_CYC(BUSY_CYC)) u_chk (
	.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
	.receive_ready_line_out(receive_ready_line_out),
	.first_vector_dark_flag_out(first_vector_dark_flag_out),
	.vector_in_progress_n_out(vector_in_progress_n_out),
	.x_conv_load_out(x_conv_load_out), .y_conv_load_out(y_conv_load_out),
	.beam_unblank_out(beam_unblank_out),
	.execute_strobe_out(execute_strobe_out), .run_pulse_out(run_pulse_out),
	.vector_done_pulse_out(vector_done_pulse_out),
	.synchronous_load_strobe_out(synchronous_load_strobe_out),
	.loads_out(loads_out), .view_out(view_out));
`default_nettype wire

// ===== vecrx_host.sv
// Purpose: host side byte strobe model
// Assumes: ready high means next byte may go
// Notes:   data inverted once ready drops
`timescale 1ns/1ps
`default_nettype none
module vecrx_host (
	input  wire logic clk_in,
	input  wire logic ready_in,
	output logic      strobe_out,
	output logic [7:0] data_out,
	output logic      stall_out
);
	initial begin
		strobe_out = 1'b0;
		data_out = 8'h00;
		stall_out = 1'b0;
	end

	// one byte: wait ready, strobe, release, wait done
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk_in);
		while (ready_in !== 1'b1 && n < 30000) begin
			@(posedge clk_in);
			n++;
		end
		strobe_out <= 1'b1;
		data_out <= b;
		do begin
			@(posedge clk_in);
			n++;
		end while (ready_in !== 1'b0 && n < 30100);
		if (ready_in !== 1'b0) stall_out <= 1'b1; // strobe never taken
		strobe_out <= 1'b0;
		data_out <= ~b; // no longer shows the byte
		repeat (3) @(posedge clk_in);
		n = 0;
		while (ready_in !== 1'b1 && n < 30000) begin
			@(posedge clk_in);
			n++;
		end
		if (n >= 30000) stall_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the vector plot receiver
// Assumes: short stretch and busy counts
// Notes:   point table first, then strap and control cases
`timescale 1ns/1ps
`default_nettype none
module tb
	import vecrx_pkg::*;
;
	typedef struct packed {
		logic gs; logic [7:0] dx; logic [31:0] b; logic [9:0] x; logic [9:0] y;
	} vecrx_row_t;
	localparam vecrx_row_t ROWS [4] = '{
		'{1'b1, 8'h40, 32'h7F7F_7F5F, 10'h3FF, 10'h3FF},
		'{1'b0, 8'h40, 32'h6060_6040, 10'h000, 10'h000},
		'{1'b0, 8'h00, 32'h756A_6A55, 10'h155, 10'h2AA},
		'{1'b1, 8'h40, 32'h6162_6344, 10'h064, 10'h022}};
	logic core_clk, arst_n = 1'b0, stb, stall, avs_rd = 1'b0, avs_wr = 1'b0;
	logic [7:0] rxd, dlt = 8'h00;
	logic [3:0] avs_a = 4'h0;
	logic [31:0] avs_wd = 32'h0000_0000, rdata, q;
	logic wreq, rdy, txt, dark, busy_n, xl, yl, ub, exs, runp, fc, vdp, wdp;
	logic sls, ex_q = 1'b0, ld_q = 1'b0, wd_q = 1'b0, ce = 1'b1;
	logic [9:0] xc, yc, px, py;
	logic [7:0] dl, dl_x = 8'hFF;
	logic [15:0] ord = 16'h0000;
	vecrx_loads_t lds;
	vecrx_view_t vw;
	int err_count = 0, checks_done = 0, n_run_pulse = 0, n_wd = 0, n_ub = 0;
	int n_tx = 0, n_fc = 0, e0, w0, u0, f0;

	vecrx_top #(.STRETCH_CYC(20), .BUSY_CYC(40)) DUT (
		.core_clk_in(core_clk), .arst_n_in(arst_n), .ce_in(ce),
		.receive_byte_strobe_in(stb), .rx_data_in(rxd), .delta_x_in(dlt),
		.delta_y_in(dlt), .avs_address_in(avs_a), .avs_read_in(avs_rd),
		.avs_write_in(avs_wr), .avs_writedata_in(avs_wd),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.receive_ready_line_out(rdy), .text_mode_flag_out(txt),
		.first_vector_dark_flag_out(dark), .vector_in_progress_n_out(busy_n),
		.x_conv_load_out(xl), .y_conv_load_out(yl), .x_conv_out(xc),
		.y_conv_out(yc), .beam_unblank_out(ub), .execute_strobe_out(exs),
		.run_pulse_out(runp), .function_complete_out(fc),
		.vector_done_pulse_out(vdp), .word_done_pulse_out(wdp),
		.synchronous_load_strobe_out(sls), .loads_out(lds),
		.latched_data_lines_out(dl), .view_out(vw));
	vecrx_host host (.clk_in(core_clk), .ready_in(rdy), .strobe_out(stb),
		.data_out(rxd), .stall_out(stall));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// event counters and load order record
	always @(posedge core_clk) begin
		ex_q <= exs;
		ld_q <= |lds;
		wd_q <= wdp;
		if (exs === 1'b1 && ex_q === 1'b0) n_run_pulse <= n_run_pulse + 1;
		if (wdp === 1'b1 && wd_q === 1'b0) n_wd <= n_wd + 1;
		if (ub === 1'b1) n_ub <= n_ub + 1;
		if (txt === 1'b1) n_tx <= n_tx + 1;
		if (fc === 1'b1) n_fc <= n_fc + 1;
		if (xl === 1'b1) dl_x <= dl;
		if ((|lds) === 1'b1 && ld_q === 1'b0)
			ord <= {ord[11:0], 2'b00, lds[1] | lds[0], lds[2] | lds[0]};
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one avalon transfer, held until waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_a <= a;
		avs_wr <= wr;
		avs_rd <= !wr;
		avs_wd <= d;
		do begin
			@(posedge core_clk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		q = rdata;
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
		if (n >= 100) err_count++;
	endtask

	task automatic summarize();
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#400_000;
		err_count++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		chk({rdy, txt, dark, busy_n, wreq, vw, exs, sls}, 10'h368);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus(1'b0, OFS_CTRL, 0); chk(q, 32'h0000_0008);
		bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
		bus(1'b0, OFS_STATUS, 0); chk(q, 32'h0000_000D);
		bus(1'b0, 4'hC, 0); chk(q, 32'h0000_0000);
		// point table, bytes in default order
		for (int i = 0; i < 4; i++) begin
			if (ROWS[i].gs) host.send(CH_GS);
			if (ROWS[i].gs) chk({dark, txt}, 2'b10);
			dlt <= ROWS[i].dx;
			e0 = n_run_pulse;
			w0 = n_wd;
			u0 = n_ub;
			f0 = n_fc;
			px = xc;
			py = yc;
			for (int j = 3; j > 0; j--) host.send(ROWS[i].b[8*j +: 8]);
			chk({xc, yc}, {px, py});
			host.send(ROWS[i].b[7:0]);
			chk({xc, yc}, {ROWS[i].x, ROWS[i].y});
			chk(ord, 16'h0123);
			chk(n_wd - w0, 3);
			chk(n_run_pulse - e0, 1);
			chk(n_fc - f0, 4);
			chk(dl_x, 8'h00);
			chk(n_ub != u0, !ROWS[i].gs && ROWS[i].dx != 0);
			chk({dl, dark, busy_n, vw}, 13'h00E);
			bus(1'b0, OFS_POS, 0);
			chk(q, {6'h00, ROWS[i].y, 6'h00, ROWS[i].x});
		end
		// strapped order low Y, high Y, low X, high X
		bus(1'b1, OFS_CTRL, 32'h0000_0009);
		for (int j = 3; j >= 0; j--) host.send(8'(32'h6A75_556A >> (8 * j)));
		chk(ord, 16'h1032);
		chk({xc, yc}, {10'h155, 10'h2AA});
		bus(1'b1, OFS_CTRL, 32'h0000_0008);
		// control character, then assembly resumes
		e0 = n_run_pulse;
		u0 = n_tx;
		host.send(CH_CR);
		chk({n_tx != u0, n_run_pulse - e0 == 1, txt}, 3'b110);
		for (int j = 3; j >= 0; j--) host.send(ROWS[1].b[8*j +: 8]);
		chk({xc, yc}, 20'h00000);
		e0 = n_run_pulse;
		host.send(CH_RS);
		host.send(CH_FS);
		chk({n_run_pulse == e0, txt}, 2'b10);
		// clock enable low: the strobe must wait untaken
		ce <= 1'b0;
		fork
			host.send(CH_US);
			begin
				repeat (30) @(posedge core_clk);
				chk(rdy, 1'b1);
				ce <= 1'b1;
			end
		join
		chk(txt, 1'b1);
		chk(stall, 1'b0);
		// reset in mid-run, then the bus answers again
		arst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({rdy, txt, dark, busy_n, wreq, vw, exs, sls}, 10'h368);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus(1'b0, OFS_STATUS, 0); chk(q, 32'h0000_000D);
		summarize();
	end
endmodule
`default_nettype wire
